// [rtl/clk_router_pkg.sv]
// Constants, encodings and functional notes for the output clock source router
// Functional notes
// - Route bits 0100 give single-ended out the 32k clock
// - Route bits 1000 give synth_c through divider 5
// - Route bits 1110 give synth_b through divider 4
// - Route bits 1101 give reference through divider 4
// - Differential out a picks synth_a, synth_b or reference
// - Differential out b uses same encoding, shared ref pick
// - 32k only single-ended; synth_a only differential outputs
// - Power-down stops clocks; ultra mode also stops config port
// - Suspend keeps oscillator only, drives 32k clock alone
// - Four stored synth_b frequencies chosen by pins, glitch-free
// - Frequency moves gradually to target, never past it
// - Enable pin role: power-down, enable, sleep detect, reset
// - Each output has slow or fast edge rate
// - Sleep detect pin watches end device clock, steers output
// - Power-down pin low stops all but enabled 32k clock
// - Plain enable role gates only single-ended output
package clk_router_pkg;

  // ----------------------------------------------------------------
  // Source selection codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_STOP = 3'b000,
    SRC_32K  = 3'b001,
    SRC_REF  = 3'b010,
    SRC_A    = 3'b011,
    SRC_B    = 3'b100,
    SRC_C    = 3'b101
  } src_sel_t;

  // ----------------------------------------------------------------
  // Power modes and enable pin roles
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_DOWN    = 2'b01,
    PWR_ULTRA   = 2'b10,
    PWR_SUSPEND = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    PIN_POWER_DOWN = 2'b00,
    PIN_OUT_ENABLE = 2'b01,
    PIN_SLEEP_DET  = 2'b10,
    PIN_RESET_OUT  = 2'b11
  } pin_role_t;

  // ----------------------------------------------------------------
  // Divider numbers and default ratios
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_NONE = 3'h0;
  localparam logic [2:0] DIV_N1   = 3'h1;
  localparam logic [2:0] DIV_N3   = 3'h3;
  localparam logic [2:0] DIV_N4   = 3'h4;
  localparam logic [2:0] DIV_N5   = 3'h5;
  localparam int unsigned DIV1_RATIO_DEF = 1;
  localparam int unsigned DIV3_RATIO_DEF = 3;
  localparam int unsigned DIV4_RATIO_DEF = 4;
  localparam int unsigned DIV5_RATIO_DEF = 5;

  // ----------------------------------------------------------------
  // Sampled input bit positions
  // ----------------------------------------------------------------
  localparam int unsigned IN_32K  = 0;
  localparam int unsigned IN_REF  = 1;
  localparam int unsigned IN_A    = 2;
  localparam int unsigned IN_B    = 3;
  localparam int unsigned IN_C    = 4;
  localparam int unsigned IN_PIN  = 5;
  localparam int unsigned IN_SEL0 = 6;
  localparam int unsigned IN_SEL1 = 7;
  localparam int unsigned IN_NUM  = 8;

  // ----------------------------------------------------------------
  // Output indices and timing counts
  // ----------------------------------------------------------------
  localparam int unsigned OUT_SE  = 0;
  localparam int unsigned OUT_DA  = 1;
  localparam int unsigned OUT_DB  = 2;
  localparam int unsigned SLEEP_TIMEOUT_DEF = 64;
  localparam int unsigned STEP_INTERVAL_DEF = 16;
  localparam int unsigned FREQ_STEP_DEF     = 8;
  localparam int unsigned FREQ_W_DEF        = 16;

endpackage : clk_router_pkg

// [rtl/output_clock_source_router.sv]
// Output clock source router: glitch-free source muxing, dividers, power and pin roles
module output_clock_source_router #(
  parameter int unsigned DIV1_RATIO    = clk_router_pkg::DIV1_RATIO_DEF,
  parameter int unsigned DIV3_RATIO    = clk_router_pkg::DIV3_RATIO_DEF,
  parameter int unsigned DIV4_RATIO    = clk_router_pkg::DIV4_RATIO_DEF,
  parameter int unsigned DIV5_RATIO    = clk_router_pkg::DIV5_RATIO_DEF,
  parameter int unsigned SLEEP_TIMEOUT = clk_router_pkg::SLEEP_TIMEOUT_DEF,
  parameter int unsigned STEP_INTERVAL = clk_router_pkg::STEP_INTERVAL_DEF,
  parameter int unsigned FREQ_STEP     = clk_router_pkg::FREQ_STEP_DEF,
  parameter int unsigned FREQ_W        = clk_router_pkg::FREQ_W_DEF
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  osc_32k_i,
  input  wire logic                  xtal_ref_i,
  input  wire logic                  synth_a_i,
  input  wire logic                  synth_b_i,
  input  wire logic                  synth_c_i,
  input  wire logic                  se_route_bit_hi_i,
  input  wire logic                  se_route_bit_lo_i,
  input  wire logic                  se_synth_b_pick_i,
  input  wire logic                  se_ref_pick_i,
  input  wire logic                  diff_a_synth_b_pick_i,
  input  wire logic                  diff_b_synth_b_pick_i,
  input  wire logic                  diff_ref_pick_i,
  input  wire logic [1:0]            power_mode_i,
  input  wire logic [1:0]            pin_role_i,
  input  wire logic                  rtc_enable_i,
  input  wire logic [2:0]            slew_fast_i,
  input  wire logic                  reset_request_i,
  input  wire logic                  output_enable_pin_a_i,
  output logic                       output_enable_pin_a_o,
  output logic                       output_enable_pin_a_oe_o,
  input  wire logic                  dfs_enable_i,
  input  wire logic [1:0]            dfs_sel_pins_i,
  input  wire logic [4*FREQ_W-1:0]   dfs_freq_words_i,
  output logic [FREQ_W-1:0]          synth_b_freq_o,
  output logic                       single_ended_out_a_o,
  output logic                       differential_out_a_o,
  output logic                       differential_out_b_o,
  output logic [2:0]                 slew_fast_o,
  output logic [2:0]                 synth_enable_o,
  output logic                       low_power_osc_en_o,
  output logic                       cfg_port_active_o,
  output logic                       end_device_asleep_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // Refuse at elaboration any value the counters cannot hold
  if (DIV1_RATIO < 1 || DIV1_RATIO > 255 || DIV3_RATIO < 1 || DIV3_RATIO > 255 ||
      DIV4_RATIO < 1 || DIV4_RATIO > 255 || DIV5_RATIO < 1 || DIV5_RATIO > 255 ||
      SLEEP_TIMEOUT < 1 || SLEEP_TIMEOUT > 65535 || STEP_INTERVAL < 1 ||
      STEP_INTERVAL > 255 || FREQ_STEP < 1 || FREQ_W < 2 || FREQ_W > 32 ||
      FREQ_STEP >= (64'd1 << FREQ_W)) begin : g_param_bad
    $error("output_clock_source_router: parameter out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [clk_router_pkg::IN_NUM-1:0] sy1;
    logic [clk_router_pkg::IN_NUM-1:0] sy2;
    logic [clk_router_pkg::IN_NUM-1:0] sy3;
    logic [clk_router_pkg::IN_NUM-1:0] flt;
    logic [2:0][2:0]                   cur_src;
    logic [2:0][2:0]                   cur_div;
    logic [2:0][7:0]                   div_cnt;
    logic [2:0]                        clk_out;
    logic [15:0]                       sleep_cnt;
    logic                              asleep;
    logic [FREQ_W-1:0]                 freq;
    logic [7:0]                        step_cnt;
    logic [2:0]                        slew;
    logic                              pin_out_en;
  } state_t;

  state_t s_q;
  state_t s_d;

  localparam logic [FREQ_W-1:0] STEP_W   = FREQ_W'(FREQ_STEP);
  localparam logic [7:0]        STEP_TOP = 8'(STEP_INTERVAL - 1);
  localparam logic [15:0]       SLP_TOP  = 16'(SLEEP_TIMEOUT);

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // Single-ended routing table; anything else stops the output
  function automatic logic [5:0] decode_se(input logic [3:0] bits);
    case (bits)
      4'b0100: decode_se = {clk_router_pkg::SRC_32K, clk_router_pkg::DIV_NONE};
      4'b1000: decode_se = {clk_router_pkg::SRC_C, clk_router_pkg::DIV_N5};
      4'b1110: decode_se = {clk_router_pkg::SRC_B, clk_router_pkg::DIV_N4};
      4'b1101: decode_se = {clk_router_pkg::SRC_REF, clk_router_pkg::DIV_N4};
      default: decode_se = {clk_router_pkg::SRC_STOP, clk_router_pkg::DIV_NONE};
    endcase
  endfunction : decode_se

  // Differential routing table, shared by both outputs
  function automatic logic [5:0] decode_diff(input logic b_pick, input logic ref_pick);
    case ({b_pick, ref_pick})
      2'b00:   decode_diff = {clk_router_pkg::SRC_A, clk_router_pkg::DIV_N1};
      2'b10:   decode_diff = {clk_router_pkg::SRC_B, clk_router_pkg::DIV_N3};
      2'b01:   decode_diff = {clk_router_pkg::SRC_REF, clk_router_pkg::DIV_N1};
      default: decode_diff = {clk_router_pkg::SRC_STOP, clk_router_pkg::DIV_NONE};
    endcase
  endfunction : decode_diff

  // Level of a filtered source
  function automatic logic src_level(input logic [2:0] src,
                                     input logic [clk_router_pkg::IN_NUM-1:0] f);
    case (src)
      clk_router_pkg::SRC_32K: src_level = f[clk_router_pkg::IN_32K];
      clk_router_pkg::SRC_REF: src_level = f[clk_router_pkg::IN_REF];
      clk_router_pkg::SRC_A:   src_level = f[clk_router_pkg::IN_A];
      clk_router_pkg::SRC_B:   src_level = f[clk_router_pkg::IN_B];
      clk_router_pkg::SRC_C:   src_level = f[clk_router_pkg::IN_C];
      default:                 src_level = 1'b0;
    endcase
  endfunction : src_level

  // Ratio of a divider number
  function automatic logic [7:0] ratio_of(input logic [2:0] div);
    case (div)
      clk_router_pkg::DIV_N1: ratio_of = 8'(DIV1_RATIO);
      clk_router_pkg::DIV_N3: ratio_of = 8'(DIV3_RATIO);
      clk_router_pkg::DIV_N4: ratio_of = 8'(DIV4_RATIO);
      clk_router_pkg::DIV_N5: ratio_of = 8'(DIV5_RATIO);
      default:                ratio_of = 8'h01;
    endcase
  endfunction : ratio_of

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [clk_router_pkg::IN_NUM-1:0] raw_in;
  assign raw_in = {dfs_sel_pins_i, output_enable_pin_a_i, synth_c_i, synth_b_i,
                   synth_a_i, xtal_ref_i, osc_32k_i};

  always_comb begin
    logic [2:0][5:0]   want;
    logic [2:0]        divided;
    logic [2:0]        src_now;
    logic [2:0]        src_rise;
    logic [7:0]        ratio;
    logic [FREQ_W-1:0] target;
    logic              pin_lvl;
    logic              pin_edge;
    logic              mode_run;
    logic              pd_pin_low;
    want       = '0;
    divided    = '0;
    src_now    = '0;
    src_rise   = '0;
    ratio      = 8'h01;
    target     = '0;
    pin_lvl    = 1'b0;
    pin_edge   = 1'b0;
    mode_run   = 1'b0;
    pd_pin_low = 1'b0;
    s_d        = s_q;
    // Three-stage sampling; a change counts when stages two and three agree
    s_d.sy1    = raw_in;
    s_d.sy2    = s_q.sy1;
    s_d.sy3    = s_q.sy2;
    for (int i = 0; i < int'(clk_router_pkg::IN_NUM); i++) begin
      if (s_q.sy2[i] == s_q.sy3[i]) begin
        s_d.flt[i] = s_q.sy3[i];
      end
    end
    pin_lvl    = s_q.flt[clk_router_pkg::IN_PIN];
    pin_edge   = s_d.flt[clk_router_pkg::IN_PIN] != pin_lvl;
    mode_run   = power_mode_i == clk_router_pkg::PWR_NORMAL;
    pd_pin_low = pin_role_i == clk_router_pkg::PIN_POWER_DOWN && !pin_lvl;
    // Sleep detect: no end device clock edge for the timeout means asleep
    if (pin_role_i != clk_router_pkg::PIN_SLEEP_DET || pin_edge) begin
      s_d.sleep_cnt = '0;
      s_d.asleep    = 1'b0;
    end else if (s_q.sleep_cnt != SLP_TOP) begin
      s_d.sleep_cnt = s_q.sleep_cnt + 16'h0001;
    end else begin
      s_d.asleep    = 1'b1;
    end
    // Wanted source per output
    want[clk_router_pkg::OUT_SE] = decode_se({se_route_bit_hi_i, se_route_bit_lo_i,
                                              se_synth_b_pick_i, se_ref_pick_i});
    want[clk_router_pkg::OUT_DA] = decode_diff(diff_a_synth_b_pick_i, diff_ref_pick_i);
    want[clk_router_pkg::OUT_DB] = decode_diff(diff_b_synth_b_pick_i, diff_ref_pick_i);
    if (power_mode_i == clk_router_pkg::PWR_SUSPEND) begin
      want[clk_router_pkg::OUT_SE] = {clk_router_pkg::SRC_32K, clk_router_pkg::DIV_NONE};
    end else if (!mode_run) begin
      want[clk_router_pkg::OUT_SE] = '0;
    end else if (pd_pin_low) begin
      want[clk_router_pkg::OUT_SE] = rtc_enable_i ?
        {clk_router_pkg::SRC_32K, clk_router_pkg::DIV_NONE} : 6'h00;
    end else if (pin_role_i == clk_router_pkg::PIN_OUT_ENABLE && !pin_lvl) begin
      want[clk_router_pkg::OUT_SE] = '0;
    end else if (pin_role_i == clk_router_pkg::PIN_SLEEP_DET && s_q.asleep) begin
      want[clk_router_pkg::OUT_SE] = {clk_router_pkg::SRC_32K, clk_router_pkg::DIV_NONE};
    end
    if (!mode_run || pd_pin_low) begin
      want[clk_router_pkg::OUT_DA] = '0;
      want[clk_router_pkg::OUT_DB] = '0;
    end
    // Dividers and glitch-free switch per output
    for (int o = 0; o < 3; o++) begin
      src_now[o]  = src_level(s_q.cur_src[o], s_d.flt);
      src_rise[o] = src_now[o] && !src_level(s_q.cur_src[o], s_q.flt);
      ratio       = ratio_of(s_q.cur_div[o]);
      if (src_rise[o]) begin
        s_d.div_cnt[o] = (s_q.div_cnt[o] + 8'h01 == ratio) ? 8'h00 : s_q.div_cnt[o] + 8'h01;
      end
      divided[o] = (ratio == 8'h01) ? src_now[o] : (s_d.div_cnt[o] < (ratio >> 1));
      s_d.clk_out[o] = divided[o];
      if (want[o] != {s_q.cur_src[o], s_q.cur_div[o]} && !s_q.clk_out[o] &&
          !src_level(want[o][5:3], s_d.flt)) begin
        s_d.cur_src[o] = want[o][5:3];
        s_d.cur_div[o] = want[o][2:0];
        // Park the count on its last low step so the first high starts on a source rise
        s_d.div_cnt[o] = ratio_of(want[o][2:0]) - 8'h01;
        s_d.clk_out[o] = 1'b0;
      end
    end
    // Stepped synth_b frequency: moves toward target without passing it
    target = dfs_freq_words_i[FREQ_W-1:0];
    if (dfs_enable_i) begin
      target = dfs_freq_words_i[int'(s_q.flt[clk_router_pkg::IN_SEL1:clk_router_pkg::IN_SEL0])
                                * FREQ_W +: FREQ_W];
    end
    s_d.step_cnt = (s_q.step_cnt == STEP_TOP) ? 8'h00 : s_q.step_cnt + 8'h01;
    if (s_q.step_cnt == STEP_TOP) begin
      if (target > s_q.freq) begin
        s_d.freq = (target - s_q.freq > STEP_W) ? s_q.freq + STEP_W : target;
      end else if (target < s_q.freq) begin
        s_d.freq = (s_q.freq - target > STEP_W) ? s_q.freq - STEP_W : target;
      end
    end
    s_d.slew       = slew_fast_i;
    s_d.pin_out_en = pin_role_i == clk_router_pkg::PIN_RESET_OUT && reset_request_i;
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign single_ended_out_a_o     = s_q.clk_out[clk_router_pkg::OUT_SE];
  assign differential_out_a_o     = s_q.clk_out[clk_router_pkg::OUT_DA];
  assign differential_out_b_o     = s_q.clk_out[clk_router_pkg::OUT_DB];
  assign slew_fast_o              = s_q.slew;
  assign synth_b_freq_o           = s_q.freq;
  assign end_device_asleep_o      = s_q.asleep;
  assign output_enable_pin_a_o    = 1'b0;          // Reset output pulls low only
  assign output_enable_pin_a_oe_o = s_q.pin_out_en;
  // Power gating of the synthesizers, oscillator and config port
  assign synth_enable_o    = (power_mode_i == clk_router_pkg::PWR_NORMAL &&
                              !(pin_role_i == clk_router_pkg::PIN_POWER_DOWN &&
                                !s_q.flt[clk_router_pkg::IN_PIN])) ? 3'b111 : 3'b000;
  assign low_power_osc_en_o = power_mode_i != clk_router_pkg::PWR_ULTRA;
  assign cfg_port_active_o  = power_mode_i == clk_router_pkg::PWR_NORMAL ||
                              power_mode_i == clk_router_pkg::PWR_DOWN;

endmodule : output_clock_source_router

// [testbench/clk_router_checker.sv]
// Concurrent checks on the router's top-level ports
module clk_router_checker #(
  parameter int unsigned FREQ_W    = 16,
  parameter int unsigned FREQ_STEP = 8
) (
  input wire logic              ref_clk_i,
  input wire logic              rstn_i,
  input wire logic [1:0]        power_mode_i,
  input wire logic [1:0]        pin_role_i,
  input wire logic              reset_request_i,
  input wire logic [2:0]        slew_fast_i,
  input wire logic              output_enable_pin_a_o,
  input wire logic              output_enable_pin_a_oe_o,
  input wire logic [FREQ_W-1:0] synth_b_freq_o,
  input wire logic              single_ended_out_a_o,
  input wire logic              differential_out_a_o,
  input wire logic              differential_out_b_o,
  input wire logic [2:0]        slew_fast_o,
  input wire logic [2:0]        synth_enable_o,
  input wire logic              low_power_osc_en_o,
  input wire logic              cfg_port_active_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Cycles spent outside normal mode, saturating
  logic [5:0] nm_cnt_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || power_mode_i == 2'h0) nm_cnt_q <= 6'h00;
    else if (nm_cnt_q != 6'h3F) nm_cnt_q <= nm_cnt_q + 6'h01;
  end

  // ----------------------------------------------------------------
  // Output pulse shapes and port checks
  // ----------------------------------------------------------------
  sequence s_se_rise;
    $rose(single_ended_out_a_o);
  endsequence
  sequence s_da_rise;
    $rose(differential_out_a_o);
  endsequence

  a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |=> !single_ended_out_a_o
      && !differential_out_a_o && !differential_out_b_o && synth_b_freq_o == '0)
    else $error("Outputs not quiet after reset");
  a_cfg_port: assert property (cfg_port_active_o == (power_mode_i inside {2'h0, 2'h1}))
    else $error("Config port activity wrong for mode");
  a_lp_osc: assert property (low_power_osc_en_o == (power_mode_i != 2'h2))
    else $error("Low power oscillator enable wrong for mode");
  a_synth_off: assert property (power_mode_i != 2'h0 |-> synth_enable_o == 3'h0)
    else $error("Synthesizers on outside normal mode");
  a_diff_stop: assert property (nm_cnt_q >= 6'h28 |-> !differential_out_a_o && !differential_out_b_o)
    else $error("Differential output running outside normal mode");
  a_oe_follow: assert property (1'b1 |=> output_enable_pin_a_oe_o
      == $past(pin_role_i == 2'h3 && reset_request_i))
    else $error("Reset output drive not one cycle after request");
  a_pin_low: assert property (output_enable_pin_a_o == 1'b0)
    else $error("Pin driven to a high level");
  a_slew_copy: assert property (1'b1 |=> slew_fast_o == $past(slew_fast_i))
    else $error("Edge rate select not copied");
  a_freq_step: assert property ($changed(synth_b_freq_o) |->
      ((synth_b_freq_o > $past(synth_b_freq_o)) ? synth_b_freq_o - $past(synth_b_freq_o)
      : $past(synth_b_freq_o) - synth_b_freq_o) <= FREQ_STEP)
    else $error("Frequency step too large");
  a_freq_space: assert property ($changed(synth_b_freq_o) |=> $stable(synth_b_freq_o))
    else $error("Frequency steps too close");
  a_se_runt: assert property (s_se_rise |=> single_ended_out_a_o [*3])
    else $error("Runt pulse on single-ended output");
  a_diff_runt: assert property (s_da_rise |=> differential_out_a_o [*2])
    else $error("Runt pulse on differential output a");
endmodule : clk_router_checker

bind output_clock_source_router clk_router_checker #(.FREQ_W(FREQ_W), .FREQ_STEP(FREQ_STEP)) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .power_mode_i(power_mode_i),
  .pin_role_i(pin_role_i), .reset_request_i(reset_request_i), .slew_fast_i(slew_fast_i),
  .output_enable_pin_a_o(output_enable_pin_a_o),
  .output_enable_pin_a_oe_o(output_enable_pin_a_oe_o), .synth_b_freq_o(synth_b_freq_o),
  .single_ended_out_a_o(single_ended_out_a_o), .differential_out_a_o(differential_out_a_o),
  .differential_out_b_o(differential_out_b_o), .slew_fast_o(slew_fast_o),
  .synth_enable_o(synth_enable_o), .low_power_osc_en_o(low_power_osc_en_o),
  .cfg_port_active_o(cfg_port_active_o));

// [testbench/clk_source_model.sv]
// Free-running model of the five source clocks feeding the router
module clk_source_model (
  input  wire logic       clk_i,
  output logic      [4:0] src_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Half periods in reference cycles: 32k, crystal, synth_a, synth_b, synth_c
  localparam int HALF [5] = '{6, 5, 3, 4, 7};
  int cnt [5] = '{default: 0};

  initial src_o = 5'h00;

  // Each source toggles once its half period has run, distinct rates per source
  always @(posedge clk_i) begin
    for (int i = 0; i < 5; i++) begin
      if (cnt[i] == HALF[i] - 1) begin
        cnt[i] <= 0;
        src_o[i] <= ~src_o[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : clk_source_model

// [testbench/tb_top.sv]
// Self-checking testbench for the output clock source router
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [63:0] WORDS = 64'h0010_0065_0037_0020;
  localparam logic [3:0] SE_CODE [7] = '{4'h4, 4'h8, 4'hE, 4'hD, 4'h0, 4'hF, 4'h6};
  localparam int SE_PER [7] = '{12, 70, 32, 40, 0, 0, 0};
  localparam int SE_HI [7] = '{6, 28, 16, 20, 0, 0, 0};
  localparam int D_PER [4] = '{6, 10, 24, 0};
  localparam int D_HI [4] = '{3, 5, 8, 0};
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] se_bits = 4'h0;
  logic da_b = 1'b0, db_b = 1'b0, d_r = 1'b0, rtc = 1'b1, req = 1'b0, pin_drv = 1'b1;
  logic dfs_en = 1'b0;
  logic [1:0] pm = 2'h0, role = 2'h1, dsel = 2'h0;
  logic [2:0] slew = 3'h0;
  wire logic [4:0] src;
  logic pin_o, pin_oe, se_o, da_o, db_o, lpo, cfg, asleep, pin_lvl;
  logic [2:0] slew_o, syn_en;
  logic [15:0] freq;
  int n_errors = 0;
  int total_checks = 0;

  always #25 ref_clk_i = ~ref_clk_i;
  // Open-drain pin: low whenever the router drives it
  assign pin_lvl = (pin_oe === 1'b1) ? pin_o : pin_drv;

  clk_source_model u_src (.clk_i(ref_clk_i), .src_o(src));
  output_clock_source_router #(.SLEEP_TIMEOUT(8), .STEP_INTERVAL(2)) uut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .osc_32k_i(src[0]), .xtal_ref_i(src[1]),
    .synth_a_i(src[2]), .synth_b_i(src[3]), .synth_c_i(src[4]),
    .se_route_bit_hi_i(se_bits[3]), .se_route_bit_lo_i(se_bits[2]),
    .se_synth_b_pick_i(se_bits[1]), .se_ref_pick_i(se_bits[0]),
    .diff_a_synth_b_pick_i(da_b), .diff_b_synth_b_pick_i(db_b), .diff_ref_pick_i(d_r),
    .power_mode_i(pm), .pin_role_i(role), .rtc_enable_i(rtc), .slew_fast_i(slew),
    .reset_request_i(req), .output_enable_pin_a_i(pin_lvl), .output_enable_pin_a_o(pin_o),
    .output_enable_pin_a_oe_o(pin_oe), .dfs_enable_i(dfs_en), .dfs_sel_pins_i(dsel),
    .dfs_freq_words_i(WORDS), .synth_b_freq_o(freq), .single_ended_out_a_o(se_o),
    .differential_out_a_o(da_o), .differential_out_b_o(db_o), .slew_fast_o(slew_o),
    .synth_enable_o(syn_en), .low_power_osc_en_o(lpo), .cfg_port_active_o(cfg),
    .end_device_asleep_o(asleep));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge ref_clk_i);
    #5;
  endtask : tick

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic outv(input int w);
    return (w == 0) ? se_o : ((w == 1) ? da_o : db_o);
  endfunction : outv

  // Settles, then measures one period and its high time; a stopped output gives zeros
  task automatic expect_clk(input string nm, input int w, input int per_e, input int hi_e);
    int per;
    int hi;
    int st;
    logic pv;
    per = 0;
    hi = 0;
    st = 0;
    repeat (80) tick();
    pv = outv(w);
    for (int n = 0; n < 300 && st < 2; n++) begin
      tick();
      if (pv === 1'b0 && outv(w) === 1'b1) st++;
      if (st == 1) per++;
      if (st == 1 && outv(w) === 1'b1) hi++;
      pv = outv(w);
    end
    check({nm, " period"}, per[15:0], per_e[15:0]);
    check({nm, " high"}, hi[15:0], hi_e[15:0]);
  endtask : expect_clk

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    n_errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) tick();
    rstn_i = 1'b1;
    repeat (60) tick();
    check("freq idle", freq, WORDS[15:0]);
    for (int k = 0; k < 7; k++) begin
      se_bits = SE_CODE[k];
      expect_clk("se", 0, SE_PER[k], SE_HI[k]);
    end
    for (int w = 1; w < 3; w++) begin
      for (int k = 0; k < 4; k++) begin
        if (w == 1) da_b = k[1];
        else db_b = k[1];
        d_r = k[0];
        expect_clk("diff", w, D_PER[k], D_HI[k]);
      end
    end
    {da_b, db_b, d_r, se_bits} = {3'h0, 4'h8};
    for (int p = 1; p < 4; p++) begin
      pm = p[1:0];
      tick();
      check("cfg port", {15'h0, cfg}, {15'h0, p < 2});
      check("lp osc", {15'h0, lpo}, {15'h0, p != 2});
      check("synth en", {13'h0, syn_en}, 16'h0000);
      expect_clk("se mode", 0, (p == 3) ? 12 : 0, (p == 3) ? 6 : 0);
      expect_clk("da mode", 1, 0, 0);
    end
    {pm, role, pin_drv, se_bits} = {2'h0, 2'h0, 1'b0, 4'hE};
    expect_clk("se pd", 0, 12, 6);
    expect_clk("da pd", 1, 0, 0);
    check("synth pd", {13'h0, syn_en}, 16'h0000);
    rtc = 1'b0;
    expect_clk("se pd nortc", 0, 0, 0);
    role = 2'h1;
    expect_clk("se oe low", 0, 0, 0);
    expect_clk("da oe low", 1, 6, 3);
    pin_drv = 1'b1;
    expect_clk("se oe high", 0, 32, 16);
    role = 2'h2;
    repeat (20) tick();
    check("asleep", {15'h0, asleep}, 16'h0001);
    expect_clk("se asleep", 0, 12, 6);
    pin_drv = 1'b0;
    repeat (6) tick();
    check("awake", {15'h0, asleep}, 16'h0000);
    repeat (14) tick();
    check("asleep again", {15'h0, asleep}, 16'h0001);
    {role, req} = {2'h3, 1'b1};
    repeat (2) tick();
    check("reset drive", {14'h0, pin_oe, pin_o}, 16'h0002);
    req = 1'b0;
    repeat (2) tick();
    check("reset idle", {15'h0, pin_oe}, 16'h0000);
    slew = 3'h5;
    tick();
    check("slew a", {13'h0, slew_o}, 16'h0005);
    slew = 3'h2;
    tick();
    check("slew b", {13'h0, slew_o}, 16'h0002);
    dfs_en = 1'b1;
    for (int k = 3; k >= 0; k--) begin
      dsel = k[1:0];
      repeat (80) tick();
      check("freq", freq, WORDS[k*16 +: 16]);
    end
    rstn_i = 1'b0;
    repeat (2) tick();
    check("reset freq", freq, 16'h0000);
    conclude();
  end
endmodule : tb_top
